// File: rtl/adccr_pkg.sv
/*
 * constants, field layout and state types of the converter control block.
 * assumes a 32-bit axi4-lite register bus and one 50 MHz system clock.
 */
package adccr_pkg;
	localparam int unsigned RES_W = 12;
	localparam int unsigned ADDR_W = 8;
	localparam int unsigned CLK_MHZ = 50;

	// register byte addresses
	localparam logic [7:0] OFS_CONV_CONTROL = 8'h00;
	localparam logic [7:0] OFS_SOURCE_CLOCK_SELECT = 8'h04;
	localparam logic [7:0] OFS_REFERENCE_SELECT = 8'h08;
	localparam logic [7:0] OFS_RESULT_LOW_BYTE = 8'h0c;
	localparam logic [7:0] OFS_RESULT_HIGH_BYTE = 8'h10;
	localparam logic [7:0] OFS_PORT_A_PIN_SHARE = 8'h14;

	// conv_control fields
	localparam int unsigned CTRL_START = 7;
	localparam int unsigned CTRL_BUSY = 6;
	localparam int unsigned CTRL_ENABLE = 5;
	localparam int unsigned CTRL_ALIGN = 4;
	localparam int unsigned CTRL_CHAN_LSB = 0;
	// source_clock_select fields
	localparam int unsigned SRC_SEL_LSB = 5;
	localparam int unsigned CLK_SEL_LSB = 0;
	// reference_select fields
	localparam int unsigned REF_AMP_EN = 7;
	localparam int unsigned REF_BG_EN = 6;
	localparam int unsigned REF_SEL_LSB = 0;
	// port_a_pin_share fields
	localparam int unsigned PIN_ANALOG_LSB = 0;
	localparam int unsigned PIN_REF_LO = 4;
	localparam int unsigned PIN_REF_HI = 5;

	// writable bits; the rest read as zero, apart from the conv_control busy bit
	localparam logic [7:0] CTRL_WMASK = 8'hb3;
	localparam logic [7:0] SRCCLK_WMASK = 8'he7;
	localparam logic [7:0] REF_WMASK = 8'hcf;
	localparam logic [7:0] PIN_WMASK = 8'h3f;
	localparam logic [7:0] REG_RESET = 8'h00;

	localparam logic [4:0] SAMPLE_TICKS = 5'h04;
	localparam logic [4:0] CONV_TICKS = 5'h10;

	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [1:0] {
		ADCCR_IDLE,
		ADCCR_SAMPLE,
		ADCCR_CONVERT
	} adccr_phase_t;

	typedef struct packed {
		adccr_phase_t phase;
		logic [4:0] tickCnt;
		logic [4:0] tickSeen;
		logic [RES_W-1:0] result;
		logic done;
	} adccr_core_t;

	typedef struct packed {
		logic awready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
		logic [7:0] ctrlReg;
		logic [7:0] srcClkReg;
		logic [7:0] refReg;
		logic [7:0] pinReg;
		logic [7:0] snapSrcClk;
		logic [1:0] snapChan;
		logic [6:0] divCnt;
		logic tick;
		logic startPulse;
		logic abortPulse;
		logic [RES_W-1:0] sampleMeta;
		logic [RES_W-1:0] sampleSync;
		logic [1:0] analogChan;
		logic extChanUsed;
		logic [2:0] internalSrc;
		logic [3:0] refSrc;
		logic ampInputBandgap;
		logic ampEnable;
		logic bgBufEnable;
		logic [3:0] analogPinMode;
		logic refPinInput;
		logic sampling;
		logic doneIrq;
	} adccr_top_t;
endpackage : adccr_pkg

// File: rtl/adccr_conv_if.sv
/*
 * link between the register side and the conversion sequencer.
 * assumes both ends run on the same system clock.
 */
`timescale 1ns/1ns
interface adccr_conv_if;
	logic tick;
	logic startPulse;
	logic abortPulse;
	logic [adccr_pkg::RES_W-1:0] sample;
	logic busy;
	logic sampling;
	logic donePulse;
	logic [adccr_pkg::RES_W-1:0] result;

	modport ctrl (
		output tick,
		output startPulse,
		output abortPulse,
		output sample,
		input busy,
		input sampling,
		input donePulse,
		input result
	);
	modport core (
		input tick,
		input startPulse,
		input abortPulse,
		input sample,
		output busy,
		output sampling,
		output donePulse,
		output result
	);
endinterface : adccr_conv_if

// File: rtl/adccr_conv_core.sv
/*
 * conversion sequencer with the analog core stub: counts converter clock ticks
 * through sampling and conversion and latches the sample at the end.
 * assumes tick is a one-cycle enable at the converter clock rate.
 */
`timescale 1ns/1ns
module adccr_conv_core (
	input wire logic clk,
	input wire logic rst_n,
	adccr_conv_if.core cv
);
	adccr_pkg::adccr_core_t q;
	adccr_pkg::adccr_core_t d;

	always_comb
	begin
		d = q;
		d.done = 1'b0;
		if (cv.abortPulse)
		begin
			d.phase = adccr_pkg::ADCCR_IDLE;
			d.tickCnt = 5'h00;
		end
		else if (cv.startPulse)
		begin
			d.phase = adccr_pkg::ADCCR_SAMPLE;
			d.tickCnt = 5'h00;
			d.tickSeen = 5'h00;
		end
		else if (cv.tick)
		begin
			case (q.phase)
				adccr_pkg::ADCCR_IDLE:
				begin
					d.tickCnt = 5'h00;
				end
				adccr_pkg::ADCCR_SAMPLE:
				begin
					d.tickCnt = 5'(q.tickCnt + 5'h01);
					d.tickSeen = 5'(q.tickSeen + 5'h01);
					if (q.tickCnt == 5'(adccr_pkg::SAMPLE_TICKS - 5'h01))
						d.phase = adccr_pkg::ADCCR_CONVERT;
				end
				adccr_pkg::ADCCR_CONVERT:
				begin
					d.tickCnt = 5'(q.tickCnt + 5'h01);
					d.tickSeen = 5'(q.tickSeen + 5'h01);
					if (q.tickCnt == 5'(adccr_pkg::CONV_TICKS - 5'h01))
					begin
						// stub core: the sample stands for the converted code
						d.phase = adccr_pkg::ADCCR_IDLE;
						d.result = cv.sample;
						d.done = 1'b1;
					end
				end
				default:
				begin
					d.phase = adccr_pkg::ADCCR_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n)
			q <= '0;
		else
			q <= d;
	end

	assign cv.busy = (q.phase != adccr_pkg::ADCCR_IDLE);
	assign cv.sampling = (q.phase == adccr_pkg::ADCCR_SAMPLE);
	assign cv.donePulse = q.done;
	assign cv.result = q.result;

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);

	start_sets_busy_a: assert property (cv.startPulse && !cv.abortPulse |=> cv.busy)
		else $error("start did not set busy");
	abort_clears_busy_a: assert property (cv.abortPulse |=> !cv.busy && !cv.donePulse)
		else $error("reset of converter left it busy");
	done_ends_busy_a: assert property (cv.donePulse |-> !cv.busy && $past(cv.busy))
		else $error("done without clearing busy");
	conv_length_a: assert property (cv.donePulse |-> q.tickSeen == 5'h10)
		else $error("conversion did not last sixteen ticks");
	sample_phase_a: assert property (q.phase == adccr_pkg::ADCCR_CONVERT |-> q.tickCnt >= 5'h04)
		else $error("conversion began before four sampling ticks");
	result_hold_a: assert property (!cv.donePulse |-> $stable(cv.result))
		else $error("result changed outside end of conversion");
endmodule : adccr_conv_core

// File: rtl/adccr_top.sv
/*
 * register file, clock divider and source routing around a 12-bit converter,
 * reached over axi4-lite.
 * assumes a single-outstanding axi4-lite master and the analog sample input
 * arriving from outside the clock domain.
 */
`timescale 1ns/1ns
module adccr_top (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [adccr_pkg::ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [adccr_pkg::ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [adccr_pkg::RES_W-1:0] analogSample,
	output logic convClock,
	output logic converterEnable,
	output logic [1:0] analogChanSel,
	output logic extChannelUsed,
	output logic [2:0] internalSourceSel,
	output logic [3:0] refSourceSel,
	output logic ampInputBandgap,
	output logic ampEnable,
	output logic bandgapBufferEnable,
	output logic [3:0] analogPinMode,
	output logic [3:0] pullHighDisable,
	output logic refPinInput,
	output logic convSampling,
	output logic convDoneIrq
);
	adccr_pkg::adccr_top_t q;
	adccr_pkg::adccr_top_t d;
	adccr_conv_if cv ();

	// result byte layout for the chosen alignment
	function automatic logic [7:0] fmtResult(
		input logic align,
		input logic [adccr_pkg::RES_W-1:0] res,
		input logic highByte
	);
		logic [7:0] b;
		b = 8'h00;
		if (!align)
			b = highByte ? res[11:4] : {res[3:0], 4'h0};
		else
			b = highByte ? {4'h0, res[11:8]} : res[7:0];
		return b;
	endfunction : fmtResult

	// code 100 acts as 000
	function automatic logic [2:0] normSrc(input logic [2:0] code);
		return (code == 3'h4) ? 3'h0 : code;
	endfunction : normSrc

	// 1001 and unlisted codes fall back to the supply reference
	function automatic logic [3:0] normRef(input logic [3:0] code);
		logic [3:0] r;
		r = 4'h0;
		if (code <= 4'h4 || (code >= 4'ha && code <= 4'hc))
			r = code;
		return r;
	endfunction : normRef

	function automatic logic [6:0] divLimit(input logic [2:0] sel);
		return 7'((8'h01 << sel) - 8'h01);
	endfunction : divLimit

	function automatic logic [7:0] readReg(
		input adccr_pkg::adccr_top_t s,
		input logic busy,
		input logic [adccr_pkg::RES_W-1:0] res,
		input logic [7:0] addr
	);
		logic [7:0] v;
		v = 8'h00;
		case (addr)
			adccr_pkg::OFS_CONV_CONTROL:
			begin
				v = s.ctrlReg;
				v[adccr_pkg::CTRL_BUSY] = busy;
			end
			adccr_pkg::OFS_SOURCE_CLOCK_SELECT: v = s.srcClkReg;
			adccr_pkg::OFS_REFERENCE_SELECT: v = s.refReg;
			adccr_pkg::OFS_RESULT_LOW_BYTE:
				v = fmtResult(s.ctrlReg[adccr_pkg::CTRL_ALIGN], res, 1'b0);
			adccr_pkg::OFS_RESULT_HIGH_BYTE:
				v = fmtResult(s.ctrlReg[adccr_pkg::CTRL_ALIGN], res, 1'b1);
			adccr_pkg::OFS_PORT_A_PIN_SHARE: v = s.pinReg;
			default: v = 8'h00;
		endcase
		return v;
	endfunction : readReg

	function automatic logic isMapped(input logic [7:0] addr);
		return addr == adccr_pkg::OFS_CONV_CONTROL || addr == adccr_pkg::OFS_SOURCE_CLOCK_SELECT
			|| addr == adccr_pkg::OFS_REFERENCE_SELECT || addr == adccr_pkg::OFS_RESULT_LOW_BYTE
			|| addr == adccr_pkg::OFS_RESULT_HIGH_BYTE || addr == adccr_pkg::OFS_PORT_A_PIN_SHARE;
	endfunction : isMapped

	always_comb
	begin
		logic [7:0] newCtrl;
		logic oldStart;
		logic oldEnable;
		logic [2:0] src;
		newCtrl = 8'h00;
		oldStart = q.ctrlReg[adccr_pkg::CTRL_START];
		oldEnable = q.ctrlReg[adccr_pkg::CTRL_ENABLE];
		src = 3'h0;
		d = q;
		d.startPulse = 1'b0;
		d.abortPulse = 1'b0;
		d.awready = 1'b0;
		d.arready = 1'b0;

		// sample crosses in from the analog side
		d.sampleMeta = analogSample;
		d.sampleSync = q.sampleMeta;

		// write channel: address and data taken together
		if (q.bvalid && s_axi_bready)
			d.bvalid = 1'b0;
		if (q.awready && s_axi_awvalid && s_axi_wvalid)
		begin
			d.bvalid = 1'b1;
			d.bresp = isMapped(s_axi_awaddr) ? adccr_pkg::RESP_OKAY : adccr_pkg::RESP_SLVERR;
			if (s_axi_wstrb[0])
			begin
				case (s_axi_awaddr)
					adccr_pkg::OFS_CONV_CONTROL:
					begin
						newCtrl = s_axi_wdata[7:0] & adccr_pkg::CTRL_WMASK;
						d.ctrlReg = newCtrl;
						if (!oldStart && newCtrl[adccr_pkg::CTRL_START])
							d.abortPulse = 1'b1;
						else if (oldStart && !newCtrl[adccr_pkg::CTRL_START]
							&& newCtrl[adccr_pkg::CTRL_ENABLE])
							d.startPulse = 1'b1;
						// disabling stops a conversion but leaves the result
						if (oldEnable && !newCtrl[adccr_pkg::CTRL_ENABLE])
							d.abortPulse = 1'b1;
					end
					adccr_pkg::OFS_SOURCE_CLOCK_SELECT:
						d.srcClkReg = s_axi_wdata[7:0] & adccr_pkg::SRCCLK_WMASK;
					adccr_pkg::OFS_REFERENCE_SELECT:
						d.refReg = s_axi_wdata[7:0] & adccr_pkg::REF_WMASK;
					adccr_pkg::OFS_PORT_A_PIN_SHARE:
						d.pinReg = s_axi_wdata[7:0] & adccr_pkg::PIN_WMASK;
					default:
					begin
						d.pinReg = q.pinReg;
					end
				endcase
			end
		end
		else if (!q.awready && !q.bvalid && s_axi_awvalid && s_axi_wvalid)
			d.awready = 1'b1;

		// read channel
		if (q.rvalid && s_axi_rready)
			d.rvalid = 1'b0;
		if (q.arready && s_axi_arvalid)
		begin
			d.rvalid = 1'b1;
			d.rdata = {24'h000000, readReg(q, cv.busy, cv.result, s_axi_araddr)};
			d.rresp = isMapped(s_axi_araddr) ? adccr_pkg::RESP_OKAY : adccr_pkg::RESP_SLVERR;
		end
		else if (!q.arready && !q.rvalid && s_axi_arvalid)
			d.arready = 1'b1;

		// source, clock and channel settings freeze while busy so later writes apply next time
		if (!cv.busy && !q.startPulse)
		begin
			d.snapSrcClk = q.srcClkReg;
			d.snapChan = q.ctrlReg[1:0];
		end

		// converter clock enable, restarted with every conversion
		d.tick = 1'b0;
		if (q.startPulse || !q.ctrlReg[adccr_pkg::CTRL_ENABLE])
			d.divCnt = 7'h00;
		else if (q.divCnt >= divLimit(q.snapSrcClk[2:0]))
		begin
			d.divCnt = 7'h00;
			d.tick = 1'b1;
		end
		else
			d.divCnt = 7'(q.divCnt + 7'h01);

		src = normSrc(q.snapSrcClk[7:5]);
		d.internalSrc = src;
		d.extChanUsed = (src == 3'h0);
		d.analogChan = q.snapChan;
		d.refSrc = normRef(q.refReg[3:0]);
		d.ampInputBandgap = q.refReg[3];
		d.ampEnable = q.refReg[adccr_pkg::REF_AMP_EN];
		d.bgBufEnable = q.refReg[adccr_pkg::REF_BG_EN];
		d.analogPinMode = q.pinReg[3:0];
		d.refPinInput = q.pinReg[adccr_pkg::PIN_REF_HI] && !q.pinReg[adccr_pkg::PIN_REF_LO];
		d.sampling = cv.sampling;
		d.doneIrq = cv.donePulse;
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n)
			q <= '0;
		else
			q <= d;
	end

	assign cv.tick = q.tick;
	assign cv.startPulse = q.startPulse;
	assign cv.abortPulse = q.abortPulse;
	assign cv.sample = q.sampleSync;

	adccr_conv_core u_core (
		.clk(clk),
		.rst_n(rst_n),
		.cv(cv)
	);

	assign s_axi_awready = q.awready;
	assign s_axi_wready = q.awready;
	assign s_axi_bvalid = q.bvalid;
	assign s_axi_bresp = q.bresp;
	assign s_axi_arready = q.arready;
	assign s_axi_rvalid = q.rvalid;
	assign s_axi_rdata = q.rdata;
	assign s_axi_rresp = q.rresp;
	assign convClock = q.tick;
	assign converterEnable = q.ctrlReg[adccr_pkg::CTRL_ENABLE];
	assign analogChanSel = q.analogChan;
	assign extChannelUsed = q.extChanUsed;
	assign internalSourceSel = q.internalSrc;
	assign refSourceSel = q.refSrc;
	assign ampInputBandgap = q.ampInputBandgap;
	assign ampEnable = q.ampEnable;
	assign bandgapBufferEnable = q.bgBufEnable;
	assign analogPinMode = q.analogPinMode;
	assign pullHighDisable = q.analogPinMode;
	assign refPinInput = q.refPinInput;
	assign convSampling = q.sampling;
	assign convDoneIrq = q.doneIrq;

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);

	low_left_align_a: assert property (s_axi_arvalid && s_axi_arready
		&& s_axi_araddr == 8'h0c && !q.ctrlReg[4]
		|=> s_axi_rdata == {24'h000000, $past(cv.result[3:0]), 4'h0})
		else $error("low byte wrong in left alignment");
	high_right_align_a: assert property (s_axi_arvalid && s_axi_arready
		&& s_axi_araddr == 8'h10 && q.ctrlReg[4]
		|=> s_axi_rdata == {28'h0000000, $past(cv.result[11:8])})
		else $error("high byte wrong in right alignment");
	upper_bits_zero_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
		else $error("bits above the byte not zero");
	busy_read_a: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr == 8'h00
		|=> s_axi_rdata[6] == $past(cv.busy))
		else $error("busy bit does not follow converter");
	reserved_zero_a: assert property (q.ctrlReg[3:2] == 2'h0 && q.srcClkReg[4:3] == 2'h0
		&& q.refReg[5:4] == 2'h0)
		else $error("unimplemented bit stored");
	internal_wins_a: assert property (normSrc($past(q.snapSrcClk[7:5])) != 3'h0
		|-> !extChannelUsed)
		else $error("external channel used with internal source");
	ref_legal_a: assert property (refSourceSel <= 4'h4
		|| (refSourceSel >= 4'ha && refSourceSel <= 4'hc))
		else $error("illegal reference code driven");
	bandgap_amp_a: assert property (ampInputBandgap == $past(q.refReg[3]))
		else $error("amplifier input not following reference top bit");
	disable_keeps_a: assert property (converterEnable ##1 !converterEnable
		|-> $stable(cv.result))
		else $error("disabling changed the result");
	// disabling or restarting legally breaks the spacing, so both cycles must be undisturbed
	tick_rate_a: assert property (q.tick && q.snapSrcClk[2:0] == 3'h1
		&& q.ctrlReg[adccr_pkg::CTRL_ENABLE] && !q.startPulse
		##1 q.ctrlReg[adccr_pkg::CTRL_ENABLE] && !q.startPulse && $stable(q.snapSrcClk)
		|-> !q.tick ##1 q.tick)
		else $error("divide by two tick spacing wrong");
endmodule : adccr_top

// File: verif/adccr_analog_model.sv
/*
 * analog front stub: turns the routed source into a distinct 12-bit code.
 * assumes the select lines come from adccr_top and hold still while converting.
 */
`timescale 1ns/1ns
module adccr_analog_model (
	input wire logic [adccr_pkg::RES_W-1:0] level,
	input wire logic converterEnable,
	input wire logic extChannelUsed,
	input wire logic [1:0] analogChanSel,
	input wire logic [2:0] internalSourceSel,
	output logic [adccr_pkg::RES_W-1:0] analogSample
);
	logic [adccr_pkg::RES_W-1:0] routed;
	always_comb
	begin
		// every route gives its own code, so a wrong route shows in the result
		if (extChannelUsed)
			routed = level ^ {10'h000, analogChanSel};
		else
			routed = level ^ {internalSourceSel, 9'h000};
		// a powered-down core yields no usable code: show the inverse
		analogSample = converterEnable ? routed : ~routed;
	end
endmodule : adccr_analog_model

// File: verif/tb_top.sv
/*
 * self-checking bench for adccr_top: axi4-lite register tasks, random
 * conversions at every clock rate, routing and reference decode checks.
 * assumes adccr_analog_model stands in for the analog core.
 */
`timescale 1ns/1ns
module tb_top;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic [7:0] s_axi_awaddr, s_axi_araddr;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [3:0] s_axi_wstrb, analogPinMode, pullHighDisable, refSourceSel;
	logic [1:0] s_axi_bresp, s_axi_rresp, analogChanSel;
	logic [11:0] level, analogSample;
	logic [2:0] internalSourceSel;
	logic convClock, converterEnable, extChannelUsed, ampInputBandgap, ampEnable;
	logic bandgapBufferEnable, refPinInput, convSampling, convDoneIrq;
	int failures = 0;
	int checks_done = 0;
	int cycleCnt = 0;
	int doneCnt = 0;
	int doneAt = 0;
	int lastTick = 0;
	int clkGap = 0;

	adccr_top dut (.clk, .rst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
		.s_axi_rvalid, .s_axi_rready, .analogSample, .convClock, .converterEnable,
		.analogChanSel, .extChannelUsed, .internalSourceSel, .refSourceSel, .ampInputBandgap,
		.ampEnable, .bandgapBufferEnable, .analogPinMode, .pullHighDisable, .refPinInput,
		.convSampling, .convDoneIrq);
	adccr_analog_model partner (.level, .converterEnable, .extChannelUsed, .analogChanSel,
		.internalSourceSel, .analogSample);

	always #10 clk = ~clk;
	always @(posedge clk)
	begin
		cycleCnt <= cycleCnt + 1;
		if (convDoneIrq === 1'b1)
		begin
			doneCnt <= doneCnt + 1;
			doneAt <= cycleCnt;
		end
		if (convClock === 1'b1)
		begin
			clkGap <= cycleCnt - lastTick;
			lastTick <= cycleCnt;
		end
		// generous ceiling: eight conversions at most 2048 cycles each plus the register traffic
		if (cycleCnt == 40000)
		begin
			failures = failures + 1;
			tally_and_finish();
		end
	end

	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : tally_and_finish

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done = checks_done + 1;
		if (got !== exp)
		begin
			failures = failures + 1;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	// an idle edge first, so a handshake signal is never assigned twice in one step
	task automatic axi_write(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
		output logic [1:0] r);
		@(posedge clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_wstrb <= s;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		@(posedge clk);
		while (s_axi_awready !== 1'b1 || s_axi_wready !== 1'b1) @(posedge clk);
		s_axi_awvalid <= 1'b0;
		s_axi_wvalid <= 1'b0;
		@(posedge clk);
		while (s_axi_bvalid !== 1'b1) @(posedge clk);
		r = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask : axi_write

	task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		@(posedge clk);
		while (s_axi_arready !== 1'b1) @(posedge clk);
		s_axi_arvalid <= 1'b0;
		@(posedge clk);
		while (s_axi_rvalid !== 1'b1) @(posedge clk);
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask : axi_read

	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		logic [1:0] r;
		axi_write(a, {24'h000000, v}, 4'hf, r);
		chk({30'h0, r}, {30'h0, adccr_pkg::RESP_OKAY});
	endtask : wr

	task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] d;
		logic [1:0] r;
		axi_read(a, d, r);
		chk(d, exp);
		chk({30'h0, r}, {30'h0, adccr_pkg::RESP_OKAY});
	endtask : rd_chk

	function automatic logic [11:0] exp_code(input logic [11:0] lv, input logic [1:0] ch,
		input logic [2:0] src);
		logic [2:0] n;
		n = (src == 3'h4) ? 3'h0 : src;
		return (n == 3'h0) ? (lv ^ {10'h000, ch}) : (lv ^ {n, 9'h000});
	endfunction : exp_code

	function automatic logic [3:0] exp_ref(input logic [3:0] c);
		return (c <= 4'h4 || (c >= 4'ha && c <= 4'hc)) ? c : 4'h0;
	endfunction : exp_ref

	task automatic check_result(input logic al, input logic [11:0] v);
		rd_chk(adccr_pkg::OFS_RESULT_LOW_BYTE, al ? {24'h0, v[7:0]} : {24'h0, v[3:0], 4'h0});
		rd_chk(adccr_pkg::OFS_RESULT_HIGH_BYTE, al ? {28'h0, v[11:8]} : {24'h0, v[11:4]});
	endtask : check_result

	task automatic settle();
		repeat (3) @(posedge clk);
	endtask : settle

	initial
	begin
		logic [31:0] d;
		logic [1:0] r;
		logic [11:0] lv;
		logic [2:0] src;
		logic [1:0] ch;
		logic al;
		int div;
		int k;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		level = 12'h000;
		d = $urandom(63);
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		for (k = 0; k < 6; k++)
			rd_chk(8'(k * 4), 32'h0);
		axi_read(8'h18, d, r);
		chk({30'h0, r}, {30'h0, adccr_pkg::RESP_SLVERR});
		chk(d, 32'h0);
		axi_write(8'h18, 32'h000000ff, 4'hf, r);
		chk({30'h0, r}, {30'h0, adccr_pkg::RESP_SLVERR});
		wr(adccr_pkg::OFS_CONV_CONTROL, 8'hff);
		rd_chk(adccr_pkg::OFS_CONV_CONTROL, 32'hb3);
		wr(adccr_pkg::OFS_SOURCE_CLOCK_SELECT, 8'hff);
		rd_chk(adccr_pkg::OFS_SOURCE_CLOCK_SELECT, 32'he7);
		// a write with lane 0 off must leave the register alone
		axi_write(adccr_pkg::OFS_SOURCE_CLOCK_SELECT, 32'h0, 4'he, r);
		rd_chk(adccr_pkg::OFS_SOURCE_CLOCK_SELECT, 32'he7);
		for (k = 0; k < 16; k++)
		begin
			if (k >= 1 && k <= 4)
				wr(adccr_pkg::OFS_PORT_A_PIN_SHARE, 8'h20);
			d = ($urandom & 32'h70) | 32'h80 | k;
			wr(adccr_pkg::OFS_REFERENCE_SELECT, d[7:0]);
			settle();
			rd_chk(adccr_pkg::OFS_REFERENCE_SELECT, d & 32'hcf);
			chk({28'h0, refSourceSel}, {28'h0, exp_ref(4'(k))});
			chk({31'h0, ampInputBandgap}, {31'h0, d[3]});
			chk({30'h0, ampEnable, bandgapBufferEnable}, {30'h0, d[7:6]});
		end
		wr(adccr_pkg::OFS_REFERENCE_SELECT, 8'h40);
		settle();
		chk({30'h0, ampEnable, bandgapBufferEnable}, 32'h1);
		for (k = 0; k < 5; k++)
		begin
			d = (k == 0) ? 32'h20 : ($urandom & 32'h3f);
			wr(adccr_pkg::OFS_PORT_A_PIN_SHARE, d[7:0]);
			settle();
			rd_chk(adccr_pkg::OFS_PORT_A_PIN_SHARE, d);
			chk({24'h0, analogPinMode, pullHighDisable}, {24'h0, d[3:0], d[3:0]});
			chk({31'h0, refPinInput}, {31'h0, d[5] & ~d[4]});
		end
		for (k = 0; k < 32; k++)
		begin
			wr(adccr_pkg::OFS_SOURCE_CLOCK_SELECT, {3'(k >> 2), 5'h00});
			wr(adccr_pkg::OFS_CONV_CONTROL, {6'h00, 2'(k)});
			settle();
			chk({30'h0, analogChanSel}, 32'(k & 3));
			chk({31'h0, extChannelUsed}, 32'((k >> 2) % 4 == 0));
			chk({29'h0, internalSourceSel}, 32'(((k >> 2) == 4) ? 0 : (k >> 2)));
		end
		// one conversion per clock rate, random source and level, both alignments
		for (k = 0; k < 8; k++)
		begin
			lv = 12'($urandom);
			src = 3'($urandom);
			ch = 2'($urandom);
			al = k[0];
			div = 1 << k;
			level <= lv;
			wr(adccr_pkg::OFS_SOURCE_CLOCK_SELECT, {src, 2'b00, 3'(k)});
			// start bit 7, busy bit 6, enable bit 5, alignment bit 4, channel bits 1:0
			wr(adccr_pkg::OFS_CONV_CONTROL, {3'h5, al, 2'b00, ch});
			rd_chk(adccr_pkg::OFS_CONV_CONTROL, {24'h0, 3'h5, al, 2'b00, ch});
			wr(adccr_pkg::OFS_CONV_CONTROL, {3'h1, al, 2'b00, ch});
			d = cycleCnt;
			div = doneCnt;
			rd_chk(adccr_pkg::OFS_CONV_CONTROL, {24'h0, 3'h3, al, 2'b00, ch});
			chk({31'h0, converterEnable}, 32'h1);
			// a channel change while busy applies only to the next conversion
			wr(adccr_pkg::OFS_CONV_CONTROL, {3'h1, al, 2'b00, ch ^ 2'h1});
			while (doneCnt == div) @(posedge clk);
			div = 1 << k;
			chk(32'(doneAt - int'(d) >= 15 * div && doneAt - int'(d) <= 16 * div + 6), 32'h1);
			chk(32'(clkGap), 32'(div));
			rd_chk(adccr_pkg::OFS_CONV_CONTROL, {24'h0, 3'h1, al, 2'b00, ch ^ 2'h1});
			check_result(al, exp_code(lv, ch, src));
			wr(adccr_pkg::OFS_CONV_CONTROL, {3'h0, ~al, 2'b00, ch});
			check_result(~al, exp_code(lv, ch, src));
		end
		// a second start rise mid-conversion resets it: busy clears and no result comes
		wr(adccr_pkg::OFS_CONV_CONTROL, 8'ha0);
		wr(adccr_pkg::OFS_CONV_CONTROL, 8'h20);
		wr(adccr_pkg::OFS_CONV_CONTROL, 8'ha0);
		div = doneCnt;
		rd_chk(adccr_pkg::OFS_CONV_CONTROL, 32'ha0);
		repeat (2200) @(posedge clk);
		chk(32'(doneCnt), 32'(div));
		tally_and_finish();
	end
endmodule : tb_top
